// >>> src/lsl_pkg.sv
package lsl_pkg;
    // ==========================================================
    // control byte layout
    localparam int PTR_W = 6;
    localparam int CTL_BANK_BIT = 6;
    localparam int CTL_MODE_BIT = 7;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] SEG_RESET = 8'h00;
    localparam int SEG_COUNT = 8;
    localparam int SEL_LSB = 3;

    // ==========================================================
    // pointer steps per received segment byte
    localparam logic [PTR_W-1:0] STEP_DIRECT = 6'h02;
    localparam logic [PTR_W-1:0] STEP_DUPLEX = 6'h01;

    // ==========================================================
    // serial framing
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam int BUF_W = 9;
    localparam int BUF_DEPTH = 2;

    // ==========================================================
    // display timing: one backplane phase
    localparam int CLK_PERIOD_NS = 8;
    localparam int PHASE_TIME_US = 2000;
    localparam int PHASE_CYCLES = (PHASE_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int PHASE_CNT_W = 20;
endpackage

// >>> src/lsl_stream_if.sv
// ==========================================================
// valid/ready byte stream between receiver, buffer and loader
interface lsl_stream_if #(parameter int W = 9);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// >>> src/lsl_sync.sv
// ==========================================================
// two flop synchroniser, first stage read by the second only
module lsl_sync
    import lsl_pkg::*;
#(
    parameter int W = 1
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] stageReg;

    // both stages reset to zero, so straps read low until sampled
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stageReg <= '0;
            q <= '0;
        end
        else
        begin
            stageReg <= d;
            q <= stageReg;
        end
    end
endmodule // lsl_sync

// >>> src/lsl_buffer.sv
// ==========================================================
// small ring buffer; full drops ready, empty drops valid
module lsl_buffer
    import lsl_pkg::*;
#(
    parameter int WIDTH = BUF_W,
    parameter int DEPTH = BUF_DEPTH
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // streams
    lsl_stream_if.snk inPort,
    lsl_stream_if.src outPort
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] memReg [DEPTH];
    logic [AW-1:0] wrPtrReg;
    logic [AW-1:0] rdPtrReg;
    logic [AW:0] countReg;
    logic pushFire;
    logic popFire;

    // honest flags straight from the occupancy count
    assign inPort.ready = (countReg != (AW+1)'(DEPTH));
    assign outPort.valid = (countReg != '0);
    assign outPort.data = memReg[rdPtrReg];
    assign pushFire = inPort.valid && inPort.ready;
    assign popFire = outPort.valid && outPort.ready;

    // storage
    always_ff @(posedge clk_sys)
    begin
        if (pushFire)
            memReg[wrPtrReg] <= inPort.data[WIDTH-1:0];
    end

    // pointers and count
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wrPtrReg <= '0;
            rdPtrReg <= '0;
            countReg <= '0;
        end
        else
        begin
            if (pushFire)
                wrPtrReg <= (wrPtrReg == AW'(DEPTH - 1)) ? '0 : wrPtrReg + 1'b1;
            if (popFire)
                rdPtrReg <= (rdPtrReg == AW'(DEPTH - 1)) ? '0 : rdPtrReg + 1'b1;
            if (pushFire && !popFire)
                countReg <= countReg + 1'b1;
            else if (popFire && !pushFire)
                countReg <= countReg - 1'b1;
        end
    end
endmodule // lsl_buffer

// >>> src/lsl_segment_loader.sv
// Behaviour
// - one control byte and eight segment bytes; even bank A, odd bank B
// - every addressed device stores the second byte as control byte
// - low control bits form the load pointer naming device and register
// - upper pointer bits must equal straps, else data dropped, bus kept
// - lower three pointer bits pick the segment byte written
// - control holds a drive-type bit and a displayed-bank bit
// - pointer advances after each segment byte
// - pointer advance carries into device-select bits
// - direct drive uses four bytes; bank 0 shows even, 1 shows odd
// - direct drive steps pointer by two
// - direct drive writes either bank whatever is displayed
// - duplex turns third strap pin into second backplane, top bit ignored
// - duplex steps pointer by one
// - duplex shows all eight bytes and ignores bank bit
// - duplex selects device with two low straps only
// - after reset backplanes low, or released when cascaded; segments low
// - reset clears all registers and the serial receiver
// - oscillator pin reads 0 when oscillating, else its tied level
// - tied oscillator pin means cascade, timed from edges of the shared first backplane
// - open third strap reads 0 via pull-down
// - all acknowledge control byte; only matched device acknowledges data
// - six-bit pointer wraps from all ones to all zeros
// - any number of segment bytes in one transfer
// - duplex even bytes on first backplane, odd on second
module lsl_segment_loader
    import lsl_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h3a, // arbitrary value
    parameter int PHASE_LEN = PHASE_CYCLES
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // serial bus, open drain
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // straps and oscillator pin
    input wire logic rcTimingPinTied,
    input wire logic rcTimingPinLevel,
    input wire logic strapBitMidIn,
    // third strap shared with second backplane
    input wire logic strapHighBpSecondIn,
    output logic strapHighBpSecondOut,
    output logic strapHighBpSecondOe,
    // first backplane
    input wire logic backplaneFirstIn,
    output logic backplaneFirstOut,
    output logic backplaneFirstOe,
    // segment drivers
    output logic [31:0] segOut
);
    // ==========================================================
    // pin synchronisers
    logic [5:0] pinSync;
    logic sclS, sdaS, tiedS, levelS, midS, highS, bpInS;
    logic bpSecInS;

    lsl_sync #(.W(6)) u_pinSync (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .d({sclIn, sdaIn, rcTimingPinTied, rcTimingPinLevel, strapBitMidIn,
            backplaneFirstIn}),
        .q(pinSync)
    );
    lsl_sync #(.W(1)) u_highSync (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .d(strapHighBpSecondIn),
        .q(bpSecInS)
    );
    assign {sclS, sdaS, tiedS, levelS, midS, bpInS} = pinSync;
    assign highS = bpSecInS;

    // ==========================================================
    // registers
    logic [7:0] controlReg;
    logic [7:0] segReg [SEG_COUNT];
    logic [PTR_W-1:0] loadPointer;
    logic duplexMode, bankSel, cascadeMode;
    logic strapBitLow, strapBitHigh, deviceMatch;

    assign loadPointer = controlReg[PTR_W-1:0];
    assign duplexMode = controlReg[CTL_MODE_BIT];
    assign bankSel = controlReg[CTL_BANK_BIT];
    assign cascadeMode = tiedS;
    assign strapBitLow = tiedS & levelS;
    assign strapBitHigh = highS; // open pin pulled low outside

    // device select: three straps in direct, two in duplex
    always_comb
    begin
        if (duplexMode)
            deviceMatch = (loadPointer[4:3] == {midS, strapBitLow});
        else
            deviceMatch = (loadPointer[5:3] == {strapBitHigh, midS, strapBitLow});
    end

    // ==========================================================
    // serial receiver: edges and start/stop detection
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_WAIT, ST_ACK,
                              ST_IGNORE} lsl_state_t;
    lsl_state_t stateReg;
    logic sclPrevReg, sdaPrevReg;
    logic sclRise, sclFall, startDet, stopDet;
    logic [7:0] shiftReg;
    logic [3:0] bitCntReg;
    logic firstByteReg, sdaOeReg, sclOeReg;
    logic pushOk, drainIdle, settleReg, drainFire;

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sclPrevReg <= 1'b1;
            sdaPrevReg <= 1'b1;
        end
        else
        begin
            sclPrevReg <= sclS;
            sdaPrevReg <= sdaS;
        end
    end
    assign sclRise = sclS && !sclPrevReg;
    assign sclFall = !sclS && sclPrevReg;
    assign startDet = sclS && sclPrevReg && sdaPrevReg && !sdaS;
    assign stopDet = sclS && sclPrevReg && !sdaPrevReg && sdaS;

    // ==========================================================
    // byte stream through the two-entry buffer
    lsl_stream_if #(.W(BUF_W)) bufIn ();
    lsl_stream_if #(.W(BUF_W)) bufOut ();

    lsl_buffer #(.WIDTH(BUF_W), .DEPTH(BUF_DEPTH)) u_buffer (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .inPort(bufIn),
        .outPort(bufOut)
    );

    // match is judged only once earlier bytes have moved the pointer
    assign drainIdle = !bufOut.valid && !settleReg;
    assign bufIn.valid = (stateReg == ST_WAIT) && drainIdle;
    assign bufIn.data = {firstByteReg, shiftReg};
    assign pushOk = bufIn.valid && bufIn.ready;

    // receiver state machine; start wins anywhere
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stateReg <= ST_IDLE;
            shiftReg <= 8'h00;
            bitCntReg <= 4'h0;
            firstByteReg <= 1'b0;
            sdaOeReg <= 1'b0;
            sclOeReg <= 1'b0;
        end
        else if (startDet)
        begin
            stateReg <= ST_ADDR;
            bitCntReg <= 4'h0;
            firstByteReg <= 1'b1;
            sdaOeReg <= 1'b0;
            sclOeReg <= 1'b0;
        end
        else if (stopDet)
        begin
            stateReg <= ST_IDLE;
            sdaOeReg <= 1'b0;
            sclOeReg <= 1'b0;
        end
        else
        begin
            case (stateReg)
                ST_ADDR, ST_DATA:
                begin
                    if (sclRise && bitCntReg != BITS_PER_BYTE)
                    begin
                        shiftReg <= {shiftReg[6:0], sdaS};
                        bitCntReg <= bitCntReg + 4'h1;
                    end
                    else if (sclFall && bitCntReg == BITS_PER_BYTE)
                    begin
                        if (stateReg == ST_DATA)
                        begin
                            stateReg <= ST_WAIT;
                            sclOeReg <= 1'b1; // stretch until loader catches up
                        end
                        else if (shiftReg[7:1] == DEV_ADDR && !shiftReg[0])
                        begin
                            stateReg <= ST_ACK;
                            sdaOeReg <= 1'b1;
                        end
                        else
                            stateReg <= ST_IGNORE; // not ours, or a read
                    end
                end
                ST_WAIT:
                begin
                    if (pushOk)
                    begin
                        stateReg <= ST_ACK;
                        sclOeReg <= 1'b0;
                        firstByteReg <= 1'b0;
                        sdaOeReg <= firstByteReg || deviceMatch;
                    end
                end
                ST_ACK:
                begin
                    if (sclFall)
                    begin
                        stateReg <= ST_DATA;
                        sdaOeReg <= 1'b0;
                        bitCntReg <= 4'h0;
                    end
                end
                ST_IDLE, ST_IGNORE:
                    stateReg <= stateReg;
                default:
                    stateReg <= ST_IDLE;
            endcase
        end
    end
    assign sdaOut = 1'b0;
    assign sdaOe = sdaOeReg;
    assign sclOut = 1'b0;
    assign sclOe = sclOeReg;

    // ==========================================================
    // loader: drains the buffer, one idle cycle after each byte
    logic drainCtl;
    logic [2:0] regSel;
    logic [PTR_W-1:0] ptrStep;

    assign bufOut.ready = !settleReg;
    assign drainFire = bufOut.valid && bufOut.ready;
    assign drainCtl = bufOut.data[8];
    assign regSel = loadPointer[SEL_LSB-1:0];
    assign ptrStep = duplexMode ? STEP_DUPLEX : STEP_DIRECT;

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            settleReg <= 1'b0;
        else
            settleReg <= drainFire;
    end

    // control byte; the pointer moves in every device, matched or not
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            controlReg <= CTL_RESET;
        else if (drainFire && drainCtl)
            controlReg <= bufOut.data[7:0];
        else if (drainFire)
            controlReg[PTR_W-1:0] <= loadPointer + ptrStep;
    end

    // segment bytes; bank shown does not block writes
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < SEG_COUNT; i++)
                segReg[i] <= SEG_RESET;
        end
        else if (drainFire && !drainCtl && deviceMatch)
            segReg[regSel] <= bufOut.data[7:0];
    end

    // ==========================================================
    // display timing: own divider, or edges of shared backplane
    logic [PHASE_CNT_W-1:0] divCntReg;
    logic bpPrevReg, phaseTick;
    logic [1:0] slotReg;

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            divCntReg <= '0;
            bpPrevReg <= 1'b0;
        end
        else
        begin
            bpPrevReg <= bpInS;
            if (cascadeMode || divCntReg == PHASE_CNT_W'(PHASE_LEN - 1))
                divCntReg <= '0;
            else
                divCntReg <= divCntReg + 1'b1;
        end
    end
    assign phaseTick = cascadeMode ? (bpInS != bpPrevReg)
                                   : (divCntReg == PHASE_CNT_W'(PHASE_LEN - 1));

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            slotReg <= 2'h0;
        else if (phaseTick)
            slotReg <= slotReg + 2'h1;
    end

    // ==========================================================
    // output drive; binary waveform, levels are left to the pads
    logic [31:0] evenBytes, oddBytes, shownBytes;
    logic activeBp, levelBit;

    assign evenBytes = {segReg[6], segReg[4], segReg[2], segReg[0]};
    assign oddBytes = {segReg[7], segReg[5], segReg[3], segReg[1]};
    assign activeBp = duplexMode && slotReg[1];
    assign levelBit = slotReg[0];

    always_comb
    begin
        if (duplexMode)
            shownBytes = activeBp ? oddBytes : evenBytes;
        else
            shownBytes = bankSel ? oddBytes : evenBytes;
    end

    // cleared bytes equal the backplane, so a reset blanks the panel
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            segOut <= 32'h0000_0000;
            backplaneFirstOut <= 1'b0;
            strapHighBpSecondOut <= 1'b0;
        end
        else
        begin
            segOut <= shownBytes ^ {32{levelBit}};
            backplaneFirstOut <= levelBit ^ activeBp;
            strapHighBpSecondOut <= levelBit ^ !activeBp;
        end
    end
    assign backplaneFirstOe = !cascadeMode;
    assign strapHighBpSecondOe = duplexMode && !cascadeMode;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    sequence segWrite;
        drainFire && !drainCtl;
    endsequence
    sequence ctlPush;
        pushOk && firstByteReg;
    endsequence

    AST_CTL_LOAD: assert property (drainFire && drainCtl |=> controlReg == $past(bufOut.data[7:0]))
        else $error("control byte not stored");
    AST_STEP_DIRECT: assert property (segWrite and !duplexMode |=> loadPointer == $past(loadPointer) + 6'h02)
        else $error("direct pointer step wrong");
    AST_STEP_DUPLEX: assert property (segWrite and duplexMode |=> loadPointer == $past(loadPointer) + 6'h01)
        else $error("duplex pointer step wrong");
    AST_NO_FOREIGN_WRITE: assert property (segWrite and !deviceMatch |=> segReg[$past(regSel)] == $past(segReg[regSel]))
        else $error("unmatched device stored data");
    AST_SEG_WRITE: assert property (segWrite and deviceMatch |=> segReg[$past(regSel)] == $past(bufOut.data[7:0]))
        else $error("segment byte not stored");
    AST_CTL_ACK: assert property (ctlPush |=> sdaOe && stateReg == ST_ACK)
        else $error("control byte not acknowledged");
    AST_DATA_NACK: assert property (pushOk && !firstByteReg && !deviceMatch |=> !sdaOe)
        else $error("unmatched device acknowledged data");
    AST_CASCADE_RELEASE: assert property (cascadeMode |-> !backplaneFirstOe && !strapHighBpSecondOe)
        else $error("backplane driven in cascade");
    AST_DUPLEX_PIN: assert property (duplexMode && !cascadeMode |-> strapHighBpSecondOe)
        else $error("second backplane not driven");
    AST_STRETCH: assert property (sclFall && stateReg == ST_DATA && bitCntReg == 4'h8 |=> sclOe && stateReg == ST_WAIT)
        else $error("clock not held while loading");
endmodule // lsl_segment_loader

// >>> verif/lsl_bus_master.sv
// ==========================================================
// two-wire bus master model; open drain, so it only releases or pulls low
module lsl_bus_master
(
    // clock
    input wire logic clk_sys,
    // resolved bus lines
    input wire logic sclLine,
    input wire logic sdaLine,
    // line release, 1 = let go
    output logic sclRel,
    output logic sdaRel
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 5; // half of the 80 ns link clock

    // idle bus: both lines released to the pull-ups
    initial
    begin
        sclRel = 1'b1;
        sdaRel = 1'b1;
    end

    task automatic waitClk(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // release scl and honour clock stretching, bounded so a stuck slave cannot hang us
    task automatic clockHigh();
        int guard;
        guard = 0;
        sclRel <= 1'b1;
        waitClk(1);
        while (!sclLine && guard < 400)
        begin
            waitClk(1);
            guard++;
        end
        waitClk(HALF);
    endtask

    // start, also usable as repeated start
    task automatic start();
        sdaRel <= 1'b1;
        waitClk(HALF);
        clockHigh();
        sdaRel <= 1'b0;
        waitClk(HALF);
        sclRel <= 1'b0;
        waitClk(2);
    endtask

    // msb first; sda only moves two cycles after scl fell, keeping hold time
    task automatic sendByte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            sdaRel <= b[i];
            waitClk(HALF);
            clockHigh();
            sclRel <= 1'b0;
            waitClk(2);
        end
        sdaRel <= 1'b1;
        waitClk(HALF);
        clockHigh();
        ack = !sdaLine;
        sclRel <= 1'b0;
        waitClk(2);
    endtask

    // stop: sda rises while scl high
    task automatic stop();
        sdaRel <= 1'b0;
        waitClk(HALF);
        clockHigh();
        sdaRel <= 1'b1;
        waitClk(HALF);
    endtask
endmodule // lsl_bus_master

// >>> verif/testbench.sv
// ==========================================================
// loader bench: bus master model, reference memory, display compare
module testbench;
    import lsl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] ADDR = 7'h3a; // arbitrary value
    localparam logic [2:0] SUB = 3'b110;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic rcTimingPinTied = 1'b0;
    logic rcTimingPinLevel = 1'b0;
    logic strapBitMidIn = SUB[1];
    logic sclOut, sclOe, sdaOut, sdaOe, sclRel, sdaRel;
    logic strapHighBpSecondOut, strapHighBpSecondOe, backplaneFirstOut, backplaneFirstOe;
    logic [31:0] segOut;
    logic [7:0] mem [8];
    logic [5:0] ptr;
    logic mode;
    int fail_count = 0;
    int checks = 0;
    int cycles = 0;
    // pins resolved from every party's enable; pull-ups on the bus
    wire sclLine = sclRel & !(sclOe & !sclOut);
    wire sdaLine = sdaRel & !(sdaOe & !sdaOut);
    wire bp2Pin = strapHighBpSecondOe ? strapHighBpSecondOut : SUB[2];
    wire bp1Pin = backplaneFirstOe ? backplaneFirstOut : 1'b0;

    always #4 clk_sys = ~clk_sys;

    lsl_bus_master m (.clk_sys(clk_sys), .sclLine(sclLine), .sdaLine(sdaLine),
        .sclRel(sclRel), .sdaRel(sdaRel));

    lsl_segment_loader #(.DEV_ADDR(ADDR), .PHASE_LEN(8)) i_dut (
        .clk_sys(clk_sys), .arst_n(arst_n), .sclIn(sclLine), .sclOut(sclOut),
        .sclOe(sclOe), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .rcTimingPinTied(rcTimingPinTied), .rcTimingPinLevel(rcTimingPinLevel),
        .strapBitMidIn(strapBitMidIn), .strapHighBpSecondIn(bp2Pin),
        .strapHighBpSecondOut(strapHighBpSecondOut),
        .strapHighBpSecondOe(strapHighBpSecondOe), .backplaneFirstIn(bp1Pin),
        .backplaneFirstOut(backplaneFirstOut), .backplaneFirstOe(backplaneFirstOe),
        .segOut(segOut));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // hang guard, far above the roughly nine thousand cycles the tests need
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            fail_count++;
            end_of_test();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
            fail_count++;
        end
    endtask

    // one write transfer; the model steps the pointer exactly as the device must
    task automatic xfer(input logic [7:0] ctl, input int n);
        logic ack;
        logic hit;
        logic [7:0] d;
        m.start();
        m.sendByte({ADDR, 1'b0}, ack);
        chk("address ack", 32'(ack), 32'h1);
        m.sendByte(ctl, ack);
        chk("control ack", 32'(ack), 32'h1);
        mode = ctl[CTL_MODE_BIT];
        ptr = ctl[PTR_W-1:0];
        repeat (n)
        begin
            d = 8'($urandom);
            hit = mode ? (ptr[4:3] == SUB[1:0]) : (ptr[5:3] == SUB);
            m.sendByte(d, ack);
            chk("data ack", 32'(ack), 32'(hit));
            if (hit)
                mem[ptr[2:0]] = d;
            ptr = ptr + (mode ? STEP_DUPLEX : STEP_DIRECT);
        end
        m.stop();
    endtask

    // direct drive view of one bank, sampled in two backplane phases
    task automatic show(input logic bank);
        xfer({1'b0, bank, 6'h00}, 0);
        repeat (20) @(posedge clk_sys);
        repeat (2)
        begin
            @(posedge clk_sys);
            #1;
            chk("segments", segOut ^ {32{backplaneFirstOut}},
                {mem[6+bank], mem[4+bank], mem[2+bank], mem[bank]});
            repeat (7) @(posedge clk_sys);
        end
    endtask

    task automatic resetCheck();
        for (int i = 0; i < 8; i++)
            mem[i] = SEG_RESET;
        chk("segments after reset", segOut, 32'h0);
        chk("backplanes after reset", 32'({backplaneFirstOut, strapHighBpSecondOe}), 32'h0);
    endtask

    // main sequence
    initial
    begin
        logic ack;
        void'($urandom(32'h8d9e));
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        resetCheck();
        $display("test reset done");
        // foreign address and read requests are ignored
        m.start();
        m.sendByte({ADDR ^ 7'h01, 1'b0}, ack);
        chk("foreign address ack", 32'(ack), 32'h0);
        m.start();
        m.sendByte({ADDR, 1'b1}, ack);
        chk("read request ack", 32'(ack), 32'h0);
        m.stop();
        $display("test addressing done");
        xfer({2'b01, 6'o60}, 5);
        xfer({2'b01, 6'o61}, 4);
        show(1'b0);
        show(1'b1);
        $display("test direct done");
        xfer({2'b10, 6'o60}, 9);
        chk("second backplane drive", 32'(strapHighBpSecondOe), 32'h1);
        show(1'b0);
        show(1'b1);
        $display("test duplex done");
        xfer({2'b00, 6'o76}, 29);
        show(1'b0);
        $display("test wrap done");
        arst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        resetCheck();
        show(1'b1);
        $display("test second reset done");
        end_of_test();
    end
endmodule // testbench
